// >>> src/clock_fail_monitor_pkg.sv
// Shared constants, register map and types of the clock fail monitor.
package clock_fail_monitor_pkg;

  // Register port geometry.
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OSC_CTRL_OFS = 2'h0;
  localparam logic [ADDR_W-1:0] INT_REQ_OFS = 2'h1;
  localparam logic [ADDR_W-1:0] INT_EN_OFS = 2'h2;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 2'h3;

  // Field positions.
  localparam int SCS_LSB = 0;
  localparam int SCS_W = 2;
  localparam int FREQ_SEL_LSB = 3;
  localparam int FREQ_SEL_W = 4;
  localparam int FAIL_FLAG_BIT = 7;
  localparam int FAIL_EN_BIT = 7;
  localparam int STAT_FAIL_SAFE_BIT = 0;
  localparam int STAT_OST_RUN_BIT = 1;
  localparam int STAT_MON_ACT_BIT = 2;
  localparam int STAT_USE_INT_BIT = 3;

  // Reset values.
  localparam logic [SCS_W-1:0] SCS_RST = 2'h0;
  localparam logic [FREQ_SEL_W-1:0] FREQ_SEL_RST = 4'h7;

  // Timing counts: sample clock divider and start-up timer length in external edges.
  localparam int LF_DIVIDE = 64;
  localparam int OST_COUNT = 1024;

  // External oscillator modes from configuration.
  typedef enum logic [2:0] {
    low_power_crystal_mode = 3'h0,
    crystal_mode = 3'h1,
    high_speed_crystal_mode = 3'h2,
    external_clock_input_mode = 3'h3,
    secondary_timer_osc = 3'h4,
    resistor_capacitor_mode = 3'h5
  } osc_mode_t;

  // Monitor states.
  typedef enum logic [2:0] {
    ST_OST = 3'b001,
    ST_MON = 3'b010,
    ST_FAIL = 3'b100
  } mon_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic use_internal;
    logic [FREQ_SEL_W-1:0] freq_sel;
  } clk_sel_t;

endpackage

// >>> src/clock_fail_monitor.sv
// Clock fail monitor: races external clock edges against a divided slow sample clock.
`timescale 1ns/100ps

// Operation
// - Failure detection runs once the start-up timer has expired, or during a restarted timer while fail-safe is set.
// - Monitor works only while the configuration enable bit is set.
// - All external oscillator modes are monitored alike.
// - Sample clock is the low-frequency internal oscillator divided by sixty-four.
// - Every external clock falling edge sets the detection latch.
// - Every sample clock rising edge clears the detection latch unless an external falling edge comes in the same cycle.
// - Failure when a whole sample half period passes without an external low edge.
// - On failure switch system clock to internal source and set the fail flag.
// - Interrupt request only when fail flag and its enable are both set.
// - Internal clock is kept after failure until firmware switches back.
// - Fallback internal frequency comes from the four-bit frequency select field.
// - Fail-safe clears on reset, sleep, or start-up timer expiry after a change of clock select bits.
// - A change of clock select bits restarts the start-up timer.
// - While the restarted timer counts, the internal oscillator keeps running the system.
// - At timer expiry fail-safe clears only after a successful switch.
// - A still failing external clock after switch back sets the flag again.
// - External clock input and RC modes skip the start-up timer.
// - Fail flag is set regardless of interrupt enable bits.
module clock_fail_monitor
  import clock_fail_monitor_pkg::*;
#(
  parameter int LF_DIV = clock_fail_monitor_pkg::LF_DIVIDE,
  parameter int OST_LEN = clock_fail_monitor_pkg::OST_COUNT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Clock sources and configuration
  input wire logic ext_clk_i,
  input wire logic low_freq_internal_osc_i,
  input wire logic monitor_enable_cfg_i,
  input wire clock_fail_monitor_pkg::osc_mode_t osc_mode_i,
  input wire logic sleep_i,
  // Register port
  input wire clock_fail_monitor_pkg::bus_req_t bus_req_i,
  output logic [clock_fail_monitor_pkg::DATA_W-1:0] rdata_o,
  // System clock mux and interrupt
  output clock_fail_monitor_pkg::clk_sel_t clk_sel_o,
  output logic fail_safe_o,
  output logic osc_fail_irq_o
);
  import clock_fail_monitor_pkg::*;

  localparam int HALF = LF_DIV / 2;
  localparam int LF_W = $clog2(HALF);
  localparam int OST_W = $clog2(OST_LEN + 1);
  localparam logic [LF_W-1:0] LF_WRAP = LF_W'(HALF - 1);
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_LEN - 1);

  logic rst_meta_r;
  logic rst_n_r;
  logic ext_d_r;
  logic lf_d_r;
  logic [LF_W-1:0] lf_cnt_r;
  logic sample_clk_r;
  logic det_latch_r;
  logic [OST_W-1:0] ost_cnt_r;
  mon_state_t state_r;
  mon_state_t state_nxt;
  logic fail_safe_r;
  logic fail_flag_r;
  logic fail_en_r;
  logic irq_r;
  logic [SCS_W-1:0] scs_r;
  logic [FREQ_SEL_W-1:0] freq_sel_r;
  clk_sel_t clk_sel_r;
  logic [DATA_W-1:0] rdata_r;

  logic ext_fall;
  logic lf_rise;
  logic sample_rise;
  logic sample_fall;
  logic half_miss;
  logic fail_det;
  logic relapse;
  logic fail_event;
  logic skip_ost;
  logic ost_done;
  logic ctrl_wr;
  logic scs_change;
  logic restart;
  logic use_internal;

  // Reset is released through two flops; the first is read only by the second.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Edge detection on the two slow sources.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_d_r <= 1'b0;
      lf_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clk_i;
      lf_d_r <= low_freq_internal_osc_i;
    end
  end

  assign ext_fall = ext_d_r & ~ext_clk_i;
  assign lf_rise = ~lf_d_r & low_freq_internal_osc_i;

  // Sample clock toggles every half of the divide ratio of slow-oscillator edges.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lf_cnt_r <= '0;
      sample_clk_r <= 1'b0;
    end else if (lf_rise) begin
      lf_cnt_r <= (lf_cnt_r == LF_WRAP) ? '0 : lf_cnt_r + 1'b1;
      if (lf_cnt_r == LF_WRAP) begin
        sample_clk_r <= ~sample_clk_r;
      end
    end
  end

  assign sample_rise = lf_rise & (lf_cnt_r == LF_WRAP) & ~sample_clk_r;
  assign sample_fall = lf_rise & (lf_cnt_r == LF_WRAP) & sample_clk_r;

  // Detection latch; an external edge in the clearing cycle still sets it.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      det_latch_r <= 1'b0;
    end else if (ext_fall) begin
      det_latch_r <= 1'b1;
    end else if (sample_rise) begin
      det_latch_r <= 1'b0;
    end
  end

  // The latch is checked at the end of the high half, one full half period after clearing.
  assign half_miss = sample_fall & ~det_latch_r & ~ext_fall;
  // Mode is not consulted: every external mode is watched the same way.
  assign fail_det = monitor_enable_cfg_i & (state_r == ST_MON) & half_miss;
  // During a switch-back attempt a dead source re-arms the fail flag.
  assign relapse = monitor_enable_cfg_i & (state_r == ST_OST) & fail_safe_r & half_miss;
  assign fail_event = fail_det | relapse;

  assign skip_ost = (osc_mode_i == external_clock_input_mode) ||
                    (osc_mode_i == resistor_capacitor_mode);
  assign ost_done = skip_ost | (ext_fall & (ost_cnt_r == OST_LAST));

  assign ctrl_wr = bus_req_i.wr & (bus_req_i.addr == OSC_CTRL_OFS);
  assign scs_change = ctrl_wr & (bus_req_i.wdata[SCS_LSB +: SCS_W] != scs_r);
  assign restart = sleep_i | scs_change;

  // Start-up timer counts external falling edges; a slow source just takes longer.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ost_cnt_r <= '0;
    end else if (restart || state_r != ST_OST) begin
      ost_cnt_r <= '0;
    end else if (ext_fall && ost_cnt_r != OST_LAST) begin
      ost_cnt_r <= ost_cnt_r + 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OST: begin
        if (restart) begin
          state_nxt = ST_OST;
        end else if (fail_event) begin
          state_nxt = ST_FAIL;
        end else if (ost_done) begin
          state_nxt = ST_MON;
        end
      end
      ST_MON: begin
        if (restart) begin
          state_nxt = ST_OST;
        end else if (fail_event) begin
          state_nxt = ST_FAIL;
        end
      end
      ST_FAIL: begin
        if (restart) begin
          state_nxt = ST_OST;
        end
      end
      default: state_nxt = ST_OST;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_OST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Fail-safe survives a clock-select change until the switch proves good.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fail_safe_r <= 1'b0;
    end else if (sleep_i) begin
      fail_safe_r <= 1'b0;
    end else if (fail_event) begin
      fail_safe_r <= 1'b1;
    end else if (state_r == ST_OST && !scs_change && ost_done) begin
      fail_safe_r <= 1'b0;
    end
  end

  // Control register holds clock select and fallback frequency.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scs_r <= SCS_RST;
      freq_sel_r <= FREQ_SEL_RST;
    end else if (ctrl_wr) begin
      scs_r <= bus_req_i.wdata[SCS_LSB +: SCS_W];
      freq_sel_r <= bus_req_i.wdata[FREQ_SEL_LSB +: FREQ_SEL_W];
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fail_flag_r <= 1'b0;
    end else if (fail_event) begin
      fail_flag_r <= 1'b1;
    end else if (bus_req_i.wr && bus_req_i.addr == INT_REQ_OFS) begin
      fail_flag_r <= bus_req_i.wdata[FAIL_FLAG_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fail_en_r <= 1'b0;
    end else if (bus_req_i.wr && bus_req_i.addr == INT_EN_OFS) begin
      fail_en_r <= bus_req_i.wdata[FAIL_EN_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= fail_flag_r & fail_en_r;
    end
  end

  // Internal source whenever not monitoring a proven external clock or selected by software.
  assign use_internal = (state_r != ST_MON) | fail_safe_r | scs_r[1];

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_sel_r <= '{use_internal: 1'b1, freq_sel: FREQ_SEL_RST};
    end else begin
      clk_sel_r <= '{use_internal: use_internal, freq_sel: freq_sel_r};
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= '0;
    end else if (bus_req_i.rd) begin
      rdata_r <= '0;
      case (bus_req_i.addr)
        OSC_CTRL_OFS: begin
          rdata_r[SCS_LSB +: SCS_W] <= scs_r;
          rdata_r[FREQ_SEL_LSB +: FREQ_SEL_W] <= freq_sel_r;
        end
        INT_REQ_OFS: rdata_r[FAIL_FLAG_BIT] <= fail_flag_r;
        INT_EN_OFS: rdata_r[FAIL_EN_BIT] <= fail_en_r;
        STATUS_OFS: begin
          rdata_r[STAT_FAIL_SAFE_BIT] <= fail_safe_r;
          rdata_r[STAT_OST_RUN_BIT] <= (state_r == ST_OST);
          rdata_r[STAT_MON_ACT_BIT] <= (state_r == ST_MON) & monitor_enable_cfg_i;
          rdata_r[STAT_USE_INT_BIT] <= clk_sel_r.use_internal;
        end
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_o = rdata_r;
  assign clk_sel_o = clk_sel_r;
  assign fail_safe_o = fail_safe_r;
  assign osc_fail_irq_o = irq_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_r);

  property p_latch_set;
    ext_fall |=> det_latch_r;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set by edge");

  property p_latch_clr;
    sample_rise && !ext_fall |=> !det_latch_r;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

  property p_divide;
    $changed(sample_clk_r) |-> $past(lf_rise) && $past(lf_cnt_r) == LF_WRAP;
  endproperty
  a_divide: assert property (p_divide) else $error("sample clock off ratio");

  property p_fail_switch;
    fail_det |=> fail_flag_r && fail_safe_r && state_r == ST_FAIL ##1 clk_sel_o.use_internal;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("failure not acted on");

  property p_irq_gate;
    !(fail_flag_r && fail_en_r) |=> !osc_fail_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

  property p_disabled;
    !monitor_enable_cfg_i |=> !$rose(fail_safe_r);
  endproperty
  a_disabled: assert property (p_disabled) else $error("failure while disabled");

  property p_no_detect_ost;
    state_r == ST_OST && !fail_safe_r |=> !$rose(fail_safe_r);
  endproperty
  a_no_detect_ost: assert property (p_no_detect_ost) else $error("detect before timer");

  property p_hold_internal;
    state_r == ST_FAIL && !restart |=> state_r == ST_FAIL ##1 clk_sel_o.use_internal;
  endproperty
  a_hold_internal: assert property (p_hold_internal) else $error("left fail-safe");

  property p_restart;
    scs_change |=> state_r == ST_OST && ost_cnt_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_sleep_clr;
    sleep_i |=> !fail_safe_r;
  endproperty
  a_sleep_clr: assert property (p_sleep_clr) else $error("sleep kept fail-safe");

  property p_clear_on_success;
    $fell(fail_safe_r) && !$past(sleep_i) |-> $past(state_r) == ST_OST && $past(ost_done);
  endproperty
  a_clear_on_success: assert property (p_clear_on_success) else $error("early clear");

  property p_skip_ost;
    state_r == ST_OST && skip_ost && !restart && !fail_event |=> state_r == ST_MON;
  endproperty
  a_skip_ost: assert property (p_skip_ost) else $error("timer not skipped");

  c_fail: cover property (fail_det);
  c_relapse: cover property (relapse);
  c_recover: cover property (state_r == ST_OST && fail_safe_r ##1 !fail_safe_r && state_r == ST_MON);
  c_irq: cover property ($rose(osc_fail_irq_o));

endmodule

// >>> dv/ext_osc_model.sv
// Behavioural external oscillator that runs at a chosen rate or dies on command.
`timescale 1ns/100ps
module ext_osc_model (
  // Control
  input wire logic run_i,
  input wire logic [15:0] half_ns_i,
  // Clock out
  output logic clk_o
);
  // A dead oscillator freezes at its last level, so no edge reaches the monitor.
  initial begin
    clk_o = 1'b0;
    forever begin
      #(half_ns_i > 0 ? half_ns_i : 1);
      if (run_i) begin
        clk_o = ~clk_o;
      end
    end
  end
endmodule

// >>> dv/clock_fail_monitor_tb.sv
// Self-checking bench for the clock fail monitor.
`timescale 1ns/100ps
module clock_fail_monitor_tb;
  import clock_fail_monitor_pkg::*;
  localparam int LFD = 4;
  localparam int OSTL = 4;
  localparam int LF_HALF = 20;
  localparam int SAMP_HALF = LFD * LF_HALF;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic lf_osc = 1'b0;
  logic en = 1'b1;
  logic sleep = 1'b0;
  logic run = 1'b1;
  logic [15:0] half = 16'd10;
  logic ext_clk;
  osc_mode_t mode = crystal_mode;
  bus_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  clk_sel_t clk_sel;
  logic fail_safe;
  logic irq;
  logic rd_d = 1'b0;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [3:0] f;

  always #2.5 clock_i = ~clock_i;
  always #(LF_HALF) lf_osc = ~lf_osc;

  ext_osc_model osc (.run_i(run), .half_ns_i(half), .clk_o(ext_clk));

  clock_fail_monitor #(.LF_DIV(LFD), .OST_LEN(OSTL)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ext_clk_i(ext_clk),
    .low_freq_internal_osc_i(lf_osc), .monitor_enable_cfg_i(en), .osc_mode_i(mode),
    .sleep_i(sleep), .bus_req_i(req), .rdata_o(rdata), .clk_sel_o(clk_sel),
    .fail_safe_o(fail_safe), .osc_fail_irq_o(irq));

  task automatic complete_run();
    // A read whose data never came back is a lost result, not a pass.
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("MISMATCH t=%0t %0d reads never answered", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [15:0] e);
    checked++;
    if ((got & e[15:8]) !== e[7:0]) begin
      n_fail++;
      $display("MISMATCH t=%0t read %h expected %h mask %h", $time, got, e[7:0], e[15:8]);
    end
  endtask

  task automatic cmp_out(input logic [4:0] got, input logic [4:0] e);
    checked++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t output %h expected %h", $time, got, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic bus(input logic [1:0] a, input logic [7:0] d, input logic w);
    @(posedge clock_i);
    req <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clock_i);
    req <= '0;
  endtask

  // The expectation is queued before the read so the watcher always finds it.
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    bus(a, 8'h00, 1'b0);
  endtask

  task automatic wait_fs(input logic e, input int lim);
    for (int i = 0; i < lim && fail_safe !== e; i++) @(posedge clock_i);
    #1;
    cmp_out(5'(fail_safe), 5'(e));
  endtask

  task automatic do_reset(input osc_mode_t m, input logic e, input logic r);
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    mode <= m;
    en <= e;
    run <= r;
    half <= 16'd10;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    step(3);
  endtask

  always @(posedge clock_i) begin
    rd_d <= req.rd;
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        cmp_rd(rdata, 16'hffff);
      end else begin
        cmp_rd(rdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'hb759));
    do_reset(crystal_mode, 1'b1, 1'b1);
    cmp_out(5'(clk_sel), 5'h17);
    rd(OSC_CTRL_OFS, 8'hff, 8'h38);
    rd(INT_REQ_OFS, 8'hff, 8'h00);
    rd(INT_EN_OFS, 8'hff, 8'h00);
    bus(STATUS_OFS, 8'hff, 1'b1);
    rd(STATUS_OFS, 8'hf0, 8'h00);
    $display("test reset done");
    for (int m = 5; m >= 0; m--) begin
      do_reset(osc_mode_t'(m[2:0]), 1'b1, 1'b1);
      step(60);
      rd(STATUS_OFS, 8'h0f, 8'h04);
      f = 4'($urandom());
      bus(OSC_CTRL_OFS, {1'b0, f, 3'h0}, 1'b1);
      @(posedge clock_i);
      run <= 1'b0;
      wait_fs(1'b1, 100);
      step(2);
      cmp_out(5'(clk_sel), {1'b1, f});
      cmp_out(5'(irq), 5'h0);
      rd(INT_REQ_OFS, 8'hff, 8'h80);
      $display("test mode %0d done", m);
    end
    bus(INT_EN_OFS, 8'h80, 1'b1);
    step(2);
    cmp_out(5'(irq), 5'h1);
    step(100);
    cmp_out(5'({fail_safe, clk_sel.use_internal}), 5'h3);
    bus(INT_REQ_OFS, 8'h00, 1'b1);
    bus(OSC_CTRL_OFS, {1'b0, f, 3'h1}, 1'b1);
    step(1);
    cmp_out(5'({fail_safe, clk_sel.use_internal}), 5'h3);
    for (int i = 0; i < 150 && irq !== 1'b1; i++) @(posedge clock_i);
    #1;
    cmp_out(5'(irq), 5'h1);
    @(posedge clock_i);
    run <= 1'b1;
    step(40);
    bus(INT_REQ_OFS, 8'h00, 1'b1);
    bus(OSC_CTRL_OFS, {1'b0, f, 3'h0}, 1'b1);
    step(1);
    cmp_out(5'(fail_safe), 5'h1);
    wait_fs(1'b0, 200);
    step(2);
    cmp_out(5'(clk_sel), {1'b0, f});
    rd(INT_REQ_OFS, 8'hff, 8'h00);
    // Select bit one forces the internal source even with a live, monitored clock.
    bus(OSC_CTRL_OFS, {1'b0, f, 3'h2}, 1'b1);
    step(40);
    cmp_out(5'(clk_sel), {1'b1, f});
    rd(STATUS_OFS, 8'h0f, 8'h0c);
    $display("test recovery done");
    @(posedge clock_i);
    run <= 1'b0;
    wait_fs(1'b1, 100);
    @(posedge clock_i);
    sleep <= 1'b1;
    @(posedge clock_i);
    sleep <= 1'b0;
    step(2);
    cmp_out(5'(fail_safe), 5'h0);
    step(150);
    cmp_out(5'(fail_safe), 5'h0);
    $display("test sleep done");
    do_reset(crystal_mode, 1'b1, 1'b0);
    step(150);
    cmp_out(5'(fail_safe), 5'h0);
    do_reset(external_clock_input_mode, 1'b1, 1'b0);
    wait_fs(1'b1, 150);
    do_reset(external_clock_input_mode, 1'b0, 1'b0);
    step(150);
    cmp_out(5'(fail_safe), 5'h0);
    rd(INT_REQ_OFS, 8'hff, 8'h00);
    $display("test start-up and disable done");
    do_reset(crystal_mode, 1'b1, 1'b1);
    @(posedge clock_i);
    half <= 16'(SAMP_HALF * 3 / 8);
    step(300);
    cmp_out(5'(fail_safe), 5'h0);
    @(posedge clock_i);
    half <= 16'(SAMP_HALF * 5 / 4);
    wait_fs(1'b1, 300);
    $display("test rate done");
    step(4);
    complete_run();
  end
endmodule
